// file: hdl/audio_bit_clock_gen.sv
`timescale 1ns/1ps
// Contract
// - Master mode divides the system clock by the selected ratio for the bit clock.
// - Field 7:4 picks 1,1.5,2,3,4,5.5,6,8,11,12,16,22,24; codes 13-15 give 32.
// - Max word length per code: 32, 20, 16, 8, or none.
// - Separate ADC bit clock on alternate pin uses the same divider.
// - Slave mode generates nothing; bit clock pin is an input.
// - In master mode ADC and DAC share one bit clock.
// - Bit 14 set drives bit clock pin as master; clear makes it input.
module audio_bit_clock_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bit_clock_in,
    output bclk_pkg::pin_out_t bit_clock_pin,
    output bclk_pkg::pin_out_t alternate_pin_eight,
    output logic bit_clock_tick
);

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    logic [15:0] clk_cfg_one_r;
    logic [15:0] dac_cfg_r;
    logic [15:0] pin_func_r;
    logic [31:0] prdata_r;
    logic [31:0] status_word;
    logic [9:0] reg_idx;
    logic hit_cfg;
    logic hit_dac;
    logic hit_pin;
    logic hit_status;
    logic mapped;
    logic wr_en;
    logic setup;

    assign reg_idx = paddr[11:bclk_pkg::ADDR_LSB];
    assign hit_cfg = (reg_idx == bclk_pkg::CLK_CFG_ONE_IDX);
    assign hit_dac = (reg_idx == bclk_pkg::DAC_CFG_IDX);
    assign hit_pin = (reg_idx == bclk_pkg::PIN_FUNC_IDX);
    assign hit_status = (reg_idx == bclk_pkg::BCLK_STATUS_IDX);
    assign mapped = hit_cfg | hit_dac | hit_pin | hit_status;
    assign setup = psel & ~penable;

    // Zero wait states; unmapped or misaligned access flags an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & (~mapped | (paddr[1:0] != 2'h0));
    assign wr_en = psel & penable & pwrite & mapped & (paddr[1:0] == 2'h0);
    assign prdata = prdata_r;

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] st);
        merge16 = old;
        if (st[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (st[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Clock configuration one, holds the divider code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_cfg_one_r <= bclk_pkg::CLK_CFG_ONE_RST;
        end else if (wr_en && hit_cfg) begin
            clk_cfg_one_r <= merge16(clk_cfg_one_r, pwdata, pstrb);
        end
    end

    // Audio port DAC configuration, holds the master enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_cfg_r <= bclk_pkg::DAC_CFG_RST;
        end else if (wr_en && hit_dac) begin
            dac_cfg_r <= merge16(dac_cfg_r, pwdata, pstrb);
        end
    end

    // Alternate pin function select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_func_r <= bclk_pkg::PIN_FUNC_RST;
        end else if (wr_en && hit_pin) begin
            pin_func_r <= merge16(pin_func_r, pwdata, pstrb);
        end
    end

    // Read data captured in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            if (hit_cfg) begin
                prdata_r <= {16'h0000, clk_cfg_one_r};
            end else if (hit_dac) begin
                prdata_r <= {16'h0000, dac_cfg_r};
            end else if (hit_pin) begin
                prdata_r <= {16'h0000, pin_func_r};
            end else if (hit_status) begin
                prdata_r <= status_word;
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode and divider selection
    // ----------------------------------------------------------------
    logic master_en;
    logic adc_sep_en;
    logic [3:0] div_code;
    logic [bclk_pkg::PER_W:0] half_units;
    logic [bclk_pkg::PER_W-1:0] period_nxt;

    assign master_en = dac_cfg_r[bclk_pkg::MASTER_BIT];
    assign adc_sep_en = pin_func_r[bclk_pkg::ADC_SEP_BIT];
    assign div_code = clk_cfg_one_r[bclk_pkg::DIV_MSB:bclk_pkg::DIV_LSB];
    assign half_units = bclk_pkg::ratio_x2(div_code);

    // ----------------------------------------------------------------
    // Master divider
    // ----------------------------------------------------------------
    logic [bclk_pkg::PER_W-1:0] cnt_r;
    logic [bclk_pkg::PER_W-1:0] period_r;
    logic alt_r;
    logic bclk_level_r;
    logic wrap;

    // Odd half-unit count: alternate floor and ceiling periods
    always_comb begin
        period_nxt = half_units[bclk_pkg::PER_W:1];
        if (half_units[0] && alt_r) begin
            period_nxt = period_nxt + 6'h01;
        end
    end

    assign wrap = (cnt_r == 6'h00);

    // Period counter; new divider codes take effect at a period boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 6'h00;
            period_r <= 6'h01;
        end else if (!master_en) begin
            cnt_r <= 6'h00;
            period_r <= 6'h01;
        end else if (wrap) begin
            cnt_r <= period_nxt - 6'h01;
            period_r <= period_nxt;
        end else begin
            cnt_r <= cnt_r - 6'h01;
        end
    end

    // Fractional phase toggles once per whole period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_r <= 1'b0;
        end else if (!master_en) begin
            alt_r <= 1'b0;
        end else if (wrap) begin
            alt_r <= ~alt_r;
        end
    end

    // Bit clock high for the first part of each period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_level_r <= 1'b0;
        end else if (!master_en) begin
            bclk_level_r <= 1'b0;
        end else if (wrap) begin
            bclk_level_r <= 1'b1;
        end else begin
            bclk_level_r <= ((cnt_r - 6'h01) >= (period_r >> 1));
        end
    end

    // One pulse per generated period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_clock_tick <= 1'b0;
        end else begin
            bit_clock_tick <= master_en & wrap;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    // DAC and ADC share the one bit clock on the main pin
    assign bit_clock_pin.drive = bclk_level_r;
    assign bit_clock_pin.enable = master_en;
    // Separate ADC bit clock follows the same divider
    assign alternate_pin_eight.drive = bclk_level_r;
    assign alternate_pin_eight.enable = master_en & adc_sep_en;

    // ----------------------------------------------------------------
    // Slave bit clock observation
    // ----------------------------------------------------------------
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic [bclk_pkg::EDGE_W-1:0] edge_cnt_r;

    // Two-stage synchroniser, then an edge history stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= bit_clock_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Counts host bit clock rising edges while in slave mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cnt_r <= 8'h00;
        end else if (!master_en && sync2_r && !sync3_r) begin
            edge_cnt_r <= edge_cnt_r + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Status word
    // ----------------------------------------------------------------
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[bclk_pkg::ST_WORD_LSB +: 6] = bclk_pkg::max_word(div_code);
        status_word[bclk_pkg::ST_MASTER_BIT] = master_en;
        status_word[bclk_pkg::ST_SLAVE_LVL_BIT] = sync2_r;
        status_word[bclk_pkg::ST_ADC_SEP_BIT] = adc_sep_en;
        status_word[bclk_pkg::ST_EDGE_LSB +: bclk_pkg::EDGE_W] = edge_cnt_r;
    end

endmodule

// file: hdl/bclk_pkg.sv
package bclk_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0] CLK_CFG_ONE_IDX = 10'h028;
    localparam logic [9:0] DAC_CFG_IDX = 10'h073;
    localparam logic [9:0] PIN_FUNC_IDX = 10'h080;
    localparam logic [9:0] BCLK_STATUS_IDX = 10'h081;
    localparam int ADDR_LSB = 2;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int DIV_LSB = 4;
    localparam int DIV_MSB = 7;
    localparam int MASTER_BIT = 14;
    localparam int ADC_SEP_BIT = 0;
    localparam logic [15:0] CLK_CFG_ONE_RST = 16'h0000;
    localparam logic [15:0] DAC_CFG_RST = 16'h0000;
    localparam logic [15:0] PIN_FUNC_RST = 16'h0000;
    localparam int REG_W = 16;

    // Status register layout
    localparam int ST_WORD_LSB = 0;
    localparam int ST_MASTER_BIT = 8;
    localparam int ST_SLAVE_LVL_BIT = 9;
    localparam int ST_ADC_SEP_BIT = 10;
    localparam int ST_EDGE_LSB = 16;
    localparam int EDGE_W = 8;

    // Divider period width, in whole system clock cycles
    localparam int PER_W = 6;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic drive;
        logic enable;
    } pin_out_t;

    // ----------------------------------------------------------------
    // Divider tables
    // ----------------------------------------------------------------
    // Twice the division ratio, so halves stay whole numbers
    function automatic logic [PER_W:0] ratio_x2(input logic [3:0] code);
        case (code)
            4'h0: ratio_x2 = 7'h02;
            4'h1: ratio_x2 = 7'h03;
            4'h2: ratio_x2 = 7'h04;
            4'h3: ratio_x2 = 7'h06;
            4'h4: ratio_x2 = 7'h08;
            4'h5: ratio_x2 = 7'h0B;
            4'h6: ratio_x2 = 7'h0C;
            4'h7: ratio_x2 = 7'h10;
            4'h8: ratio_x2 = 7'h16;
            4'h9: ratio_x2 = 7'h18;
            4'hA: ratio_x2 = 7'h20;
            4'hB: ratio_x2 = 7'h2C;
            4'hC: ratio_x2 = 7'h30;
            default: ratio_x2 = 7'h40;
        endcase
    endfunction

    // Longest word carried at full sample rate, zero for none
    function automatic logic [5:0] max_word(input logic [3:0] code);
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4: max_word = 6'h20;
            4'h5, 4'h6: max_word = 6'h14;
            4'h7: max_word = 6'h10;
            4'h8, 4'h9, 4'hA: max_word = 6'h08;
            default: max_word = 6'h00;
        endcase
    endfunction

endpackage

// file: bench/host_bclk_model.sv
`timescale 1ns/1ps
module host_bclk_model #(parameter int HALF = 3) (
    input wire logic pclk,
    input wire logic run,
    output logic level
);
    int cnt_r;
    initial begin
        level = 1'b0;
        cnt_r = 0;
    end
    // Host bit clock while running, parked low when released
    always @(posedge pclk) begin
        if (!run) begin
            cnt_r <= 0;
            level <= 1'b0;
        end else begin
            cnt_r <= (cnt_r + 1) % HALF;
            if (cnt_r == HALF - 1) begin
                level <= ~level;
            end
        end
    end
endmodule

// file: bench/audio_bit_clock_gen_sva.sv
`timescale 1ns/1ps
module bclk_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire bclk_pkg::pin_out_t bit_clock_pin,
    input wire bclk_pkg::pin_out_t alternate_pin_eight,
    input wire logic bit_clock_tick
);
    localparam logic [7:0] R2 [16] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0B, 8'h0C, 8'h10,
        8'h16, 8'h18, 8'h20, 8'h2C, 8'h30, 8'h40, 8'h40, 8'h40};
    localparam logic [5:0] WORD [16] = '{6'h20, 6'h20, 6'h20, 6'h20, 6'h20, 6'h14, 6'h14, 6'h10,
        6'h08, 6'h08, 6'h08, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};
    logic master_r, sep_r;
    logic [3:0] code_r;
    logic [7:0] gap_r, prev_r;
    logic [2:0] settled_r;
    wire wr = psel && penable && pwrite && pready;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of the control fields and tick spacing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_r <= 1'b0;
            sep_r <= 1'b0;
            code_r <= 4'h0;
            gap_r <= 8'h00;
            prev_r <= 8'h00;
            settled_r <= 3'h0;
        end else begin
            if (wr && paddr == 12'h1CC) master_r <= pwdata[14];
            if (wr && paddr == 12'h0A0) code_r <= pwdata[7:4];
            if (wr && paddr == 12'h200) sep_r <= pwdata[0];
            gap_r <= bit_clock_tick ? 8'h01 : gap_r + 8'h01;
            if (bit_clock_tick) prev_r <= gap_r;
            if (wr) settled_r <= 3'h0;
            else if (bit_clock_tick && settled_r != 3'h7) settled_r <= settled_r + 3'h1;
        end
    end
    sequence master_on;
        $rose(master_r);
    endsequence
    sequence drive_up;
        ##[1:2] bit_clock_pin.drive;
    endsequence
    master_start_a: assert property (master_on |-> drive_up)
        else $error("bit clock did not start after master enable");
    pin_enable_a: assert property (bit_clock_pin.enable == master_r)
        else $error("bit clock pin direction wrong");
    alt_enable_a: assert property (alternate_pin_eight.enable == (master_r && sep_r))
        else $error("alternate pin enable wrong");
    shared_drive_a: assert property (alternate_pin_eight.drive == bit_clock_pin.drive)
        else $error("alternate pin level differs from bit clock");
    slave_quiet_a: assert property (!master_r && !$past(master_r) |->
        !bit_clock_pin.drive && !bit_clock_tick)
        else $error("bit clock activity in slave mode");
    tick_high_a: assert property (bit_clock_tick |-> bit_clock_pin.drive)
        else $error("tick while bit clock low");
    period_sum_a: assert property (bit_clock_tick && settled_r >= 3'h4 |->
        gap_r + prev_r == R2[code_r] && 8'(gap_r - prev_r + 8'h01) <= 8'h02)
        else $error("bit clock period wrong for divider code");
    status_word_a: assert property (psel && penable && !pwrite && paddr == 12'h204 |->
        prdata[5:0] == WORD[code_r] && prdata[8] == master_r)
        else $error("status word length wrong");
endmodule

// file: bench/audio_bit_clock_gen_test.sv
`timescale 1ns/1ps
module audio_bit_clock_gen_test;
    localparam logic [7:0] R2 [16] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0B, 8'h0C, 8'h10,
        8'h16, 8'h18, 8'h20, 8'h2C, 8'h30, 8'h40, 8'h40, 8'h40};
    localparam logic [5:0] WORD [16] = '{6'h20, 6'h20, 6'h20, 6'h20, 6'h20, 6'h14, 6'h14, 6'h10,
        6'h08, 6'h08, 6'h08, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};
    logic pclk, presetn, psel, penable, pwrite, host_run, host_level;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic pready, pslverr, bit_clock_tick, e;
    bclk_pkg::pin_out_t bit_clock_pin, alternate_pin_eight;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    wire pin_level = bit_clock_pin.enable ? bit_clock_pin.drive : host_level;
    audio_bit_clock_gen dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bit_clock_in(pin_level),
        .bit_clock_pin(bit_clock_pin), .alternate_pin_eight(alternate_pin_eight),
        .bit_clock_tick(bit_clock_tick));
    host_bclk_model host (.pclk(pclk), .run(host_run), .level(host_level));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic give_verdict;
        if (err_total == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic next_tick(output int g);
        g = 0;
        do begin
            @(negedge pclk);
            g++;
        end while (bit_clock_tick !== 1'b1 && g < 200);
    endtask
    task automatic t_reset;
        apb(1'b1, 12'h0A2, 32'hFFFF_FFFF);
        chk(32'(e), 32'h1);
        apb(1'b0, 12'h0A0, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 12'h1CC, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({r[30:0], e}, 32'h1);
        apb(1'b0, 12'h204, 32'h0);
        chk(32'({r[8], r[5:0]}), 32'h20);
    endtask
    // Every divider code, settings chosen as software would
    task automatic t_divider;
        int g0, g1, g2;
        apb(1'b1, 12'h1CC, 32'h0000_4000);
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 12'h0A0, 32'(c) << 4);
            repeat (3) next_tick(g0);
            next_tick(g1);
            next_tick(g2);
            chk(32'(g1 + g2), 32'(R2[c]));
            chk(32'(g1 == g2), 32'(!R2[c][0]));
            apb(1'b0, 12'h204, 32'h0);
            chk(32'({r[8], r[5:0]}), 32'({1'b1, WORD[c]}));
        end
    endtask
    // Separate ADC clock on the alternate pin
    task automatic t_adc;
        apb(1'b1, 12'h0A0, 32'h0000_0020);
        apb(1'b1, 12'h200, 32'h1);
        repeat (12) begin
            @(negedge pclk);
            chk(32'(alternate_pin_eight.enable), 32'h1);
            chk(32'(alternate_pin_eight.drive), 32'(bit_clock_pin.drive));
        end
        apb(1'b0, 12'h204, 32'h0);
        chk(32'(r[10]), 32'h1);
        apb(1'b1, 12'h200, 32'h0);
        @(negedge pclk);
        chk(32'(alternate_pin_eight.enable), 32'h0);
    endtask
    task automatic t_slave;
        logic [7:0] first;
        apb(1'b1, 12'h1CC, 32'h0);
        host_run <= 1'b1;
        apb(1'b0, 12'h204, 32'h0);
        first = r[23:16];
        repeat (40) begin
            @(negedge pclk);
            chk(32'({bit_clock_pin, bit_clock_tick}), 32'h0);
        end
        apb(1'b0, 12'h204, 32'h0);
        chk(32'(r[23:16] != first), 32'h1);
        host_run <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, 12'h204, 32'h0);
        chk(32'(r[9]), 32'h0);
    endtask
    // Cut a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict;
        end
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        host_run = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_divider;
        t_adc;
        t_slave;
        give_verdict;
    end
endmodule
bind audio_bit_clock_gen bclk_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .bit_clock_pin(bit_clock_pin), .alternate_pin_eight(alternate_pin_eight),
    .bit_clock_tick(bit_clock_tick));
